/* cis_consts.svh */
// constants for the current input code scaler: offsets, clamp codes,
// thresholds and scaling factors.
// assumes currents arrive as signed microamps and codes leave as 16 bits.
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH

// ****************************************
// channel layout
// ****************************************
`define CIS_NCH          8
`define CIS_CH_W         3
`define CIS_CUR_W        18
`define CIS_RANGE_RESET  3'h2

// ****************************************
// current thresholds in microamps
// ****************************************
`define CIS_I_ZERO       18'sh00000
`define CIS_I_4MA        18'sh00fa0
`define CIS_I_20MA       18'sh04e20
`define CIS_I_20MA24     18'sh04f10
`define CIS_I_NEG20MA    (-18'sh04e20)
`define CIS_I_BIP_SHIFT  19'sh04e20

// ****************************************
// scaling factors: code = (mul * i - sub * den) / den
// ****************************************
`define CIS_MUL_FULL     17'h0ffff
`define CIS_MUL_S27      17'h06c00
`define CIS_DEN_16MA     16'h3e80
`define CIS_DEN_20MA     16'h4e20
`define CIS_DEN_40MA     16'h9c40
`define CIS_SUB_FULL     16'h4000
`define CIS_SUB_S27      16'h1b00

// ****************************************
// clamp codes
// ****************************************
`define CIS_CODE_MIN     16'h0000
`define CIS_CODE_MAX     16'hffff
`define CIS_CODE_OVR_4   16'h6db5
`define CIS_CODE_OVR_0   16'h6d52

// ****************************************
// divider geometry
// ****************************************
`define CIS_NUM_W        32
`define CIS_DEN_W        16

`endif

/* cis_pkg.sv */
// types shared by the current input code scaler files.
// assumes nothing of its surroundings.
package cis_pkg;

    // range selector codes held per channel
    typedef enum logic [2:0]
    {
        CIS_RNG_OFF       = 3'b000,
        CIS_RNG_4_20_FULL = 3'b001,
        CIS_RNG_0_20_FULL = 3'b010,
        CIS_RNG_4_20_S27  = 3'b011,
        CIS_RNG_0_20_S27  = 3'b100,
        CIS_RNG_BIPOLAR   = 3'b101
    } cis_range_t;

    // conversion sequencer
    typedef enum logic [0:0]
    {
        CIS_IDLE = 1'b0,
        CIS_DIV  = 1'b1
    } cis_state_t;

endpackage : cis_pkg

/* cis_div_if.sv */
// request and answer wires between the scaler and its divider.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "cis_consts.svh"

interface cis_div_if;
    logic                    start;
    logic [`CIS_NUM_W-1:0]   numer;
    logic [`CIS_DEN_W-1:0]   denom;
    logic                    done;
    logic [`CIS_NUM_W-1:0]   quot;

    modport req  (output start, output numer, output denom, input done, input quot);
    modport calc (input start, input numer, input denom, output done, output quot);
endinterface : cis_div_if

/* cis_divider.sv */
// serial restoring divider, one quotient bit per clock.
// assumes start is only raised while the previous division has finished.
`timescale 1ns/1ps
`include "cis_consts.svh"

module cis_divider
    import cis_pkg::*;
#(
    parameter int NUM_W = `CIS_NUM_W,
    parameter int DEN_W = `CIS_DEN_W
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    cis_div_if.calc   div
);

    logic [DEN_W:0]   rem_q;
    logic [NUM_W-1:0] quot_q;
    logic [DEN_W-1:0] den_q;
    logic [5:0]       cnt_q;
    logic             busy_q;
    logic             done_q;
    logic [DEN_W:0]   remShift;
    logic             fits;

    // shift in the next numerator bit and try the subtraction
    assign remShift = {rem_q[DEN_W-1:0], quot_q[NUM_W-1]};
    assign fits     = remShift >= {1'b0, den_q};

    // ****************************************
    // iteration
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rem_q  <= '0;
            quot_q <= '0;
            den_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (ce)
        begin
            done_q <= 1'b0;
            if (div.start)
            begin
                rem_q  <= '0;
                quot_q <= div.numer;
                den_q  <= div.denom;
                cnt_q  <= 6'(NUM_W);
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                rem_q  <= fits ? remShift - {1'b0, den_q} : remShift;
                quot_q <= {quot_q[NUM_W-2:0], fits};
                cnt_q  <= cnt_q - 6'h01;
                if (cnt_q == 6'h01)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1; // quotient complete
                end
            end
        end
    end

    assign div.done = done_q;
    assign div.quot = quot_q;

endmodule : cis_divider

/* cis_scaler.sv */
// per-channel current input scaler: turns signed microamp samples into
// range codes, with clamping, overshoot band and overflow alarms.
// assumes samples and settings are synchronous to clk; outputs are not
// back-pressured, the reader takes every code pulse.
//
// How it works
// R1: selector 0 off, 1-5 ranges, resets 2
// R2: 4-20 full: 65535/16 times I minus 16384
// R3: 4-20 full: below 4 mA gives 0
// R4: 4-20 full and bipolar: above 20 mA max
// R5: 0-20 full: code is 65535/20 times I
// R6: 0-20 full: above 20 mA gives 65535
// R7: 0-20 full: below 0 mA gives 0
// R8: 4-20 27648: 27648/16 times I minus 6912
// R9: 4-20 27648: linear up to 20.24 mA
// R10: 4-20 27648: above 20.24 mA 28085, alarm
// R11: 4-20 27648: below 4 mA gives 0
// R12: 0-20 27648: code is 27648/20 times I
// R13: 0-20 27648: linear up to 20.24 mA
// R14: 0-20 27648: above 20.24 mA 27986, alarm
// R15: 0-20 27648: below 0 mA gives 0
// R16: bipolar: 65535/40 times (I plus 20)
// R17: bipolar: below -20 mA gives 0
// R18: scaled results round to nearest code
// R19: alarm held, cleared when back or disabled
`timescale 1ns/1ps
`include "cis_consts.svh"

module cis_scaler
    import cis_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic                          cfgValid,
    input  wire logic [`CIS_CH_W-1:0]          cfgChan,
    input  wire logic [2:0]                    cfgRange,
    input  wire logic                          sampleValid,
    output logic                               sampleReady,
    input  wire logic [`CIS_CH_W-1:0]          sampleChan,
    input  wire logic signed [`CIS_CUR_W-1:0]  sampleCurrent,
    output logic                               codeValid,
    output logic [`CIS_CH_W-1:0]               codeChan,
    output logic [15:0]                        codeValue,
    output logic [`CIS_NCH-1:0]                overflowAlarm
);

    // ****************************************
    // declarations
    // ****************************************
    cis_range_t                rangeSel_q [`CIS_NCH];
    cis_state_t                state_q;
    logic [`CIS_CH_W-1:0]      pendChan_q;
    logic                      codeValid_q;
    logic [`CIS_CH_W-1:0]      codeChan_q;
    logic [15:0]               codeValue_q;
    logic [`CIS_NCH-1:0]       alarm_q;
    cis_range_t                accRange;
    logic                      accept;
    logic                      chanOff;
    logic                      lowHit;
    logic                      highHit;
    logic                      overHit;
    logic [15:0]               clampCode;
    logic [16:0]               mulC;
    logic [15:0]               denC;
    logic [15:0]               subC;
    logic signed [18:0]        curAdj;
    logic [31:0]               subDen;
    logic signed [39:0]        numS;
    logic                      divFinish;
    logic [15:0]               divCode;
    logic                      cfgLegal;

    cis_div_if div ();

    // ****************************************
    // range settings
    // ****************************************
    assign cfgLegal = cfgRange <= CIS_RNG_BIPOLAR;

    // one selector per channel, illegal codes are ignored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `CIS_NCH; i++)
            begin
                rangeSel_q[i] <= cis_range_t'(`CIS_RANGE_RESET); // R1
            end
        end
        else if (ce && cfgValid && cfgLegal)
        begin
            rangeSel_q[cfgChan] <= cis_range_t'(cfgRange); // R1
        end
    end

    // ****************************************
    // sample decode
    // ****************************************
    assign sampleReady = state_q == CIS_IDLE;
    assign accept      = ce && sampleValid && sampleReady;
    assign accRange    = rangeSel_q[sampleChan];
    assign chanOff     = accRange == CIS_RNG_OFF; // R1

    // clamp decisions per range
    always_comb
    begin
        lowHit    = 1'b0;
        highHit   = 1'b0;
        overHit   = 1'b0;
        clampCode = `CIS_CODE_MIN;
        case (accRange)
            CIS_RNG_4_20_FULL:
            begin
                lowHit  = sampleCurrent < `CIS_I_4MA; // R3
                highHit = sampleCurrent > `CIS_I_20MA; // R4
            end
            CIS_RNG_0_20_FULL:
            begin
                lowHit  = sampleCurrent < `CIS_I_ZERO; // R7
                highHit = sampleCurrent > `CIS_I_20MA; // R6
            end
            CIS_RNG_4_20_S27:
            begin
                lowHit  = sampleCurrent < `CIS_I_4MA; // R11
                overHit = sampleCurrent > `CIS_I_20MA24; // R9 R10
            end
            CIS_RNG_0_20_S27:
            begin
                lowHit  = sampleCurrent < `CIS_I_ZERO; // R15
                overHit = sampleCurrent > `CIS_I_20MA24; // R13 R14
            end
            CIS_RNG_BIPOLAR:
            begin
                lowHit  = sampleCurrent < `CIS_I_NEG20MA; // R17
                highHit = sampleCurrent > `CIS_I_20MA; // R4
            end
            default:
            begin
                lowHit = 1'b0;
            end
        endcase
        if (highHit)
        begin
            clampCode = `CIS_CODE_MAX; // R4 R6
        end
        else if (overHit && accRange == CIS_RNG_4_20_S27)
        begin
            clampCode = `CIS_CODE_OVR_4; // R10
        end
        else if (overHit)
        begin
            clampCode = `CIS_CODE_OVR_0; // R14
        end
    end

    // scaling factors per range
    always_comb
    begin
        mulC = `CIS_MUL_FULL;
        denC = `CIS_DEN_20MA;
        subC = 16'h0000;
        case (accRange)
            CIS_RNG_4_20_FULL:
            begin
                denC = `CIS_DEN_16MA; // R2
                subC = `CIS_SUB_FULL;
            end
            CIS_RNG_4_20_S27:
            begin
                mulC = `CIS_MUL_S27; // R8
                denC = `CIS_DEN_16MA;
                subC = `CIS_SUB_S27;
            end
            CIS_RNG_0_20_S27:
            begin
                mulC = `CIS_MUL_S27; // R12
            end
            CIS_RNG_BIPOLAR:
            begin
                denC = `CIS_DEN_40MA; // R16
            end
            default:
            begin
                denC = `CIS_DEN_20MA; // R5
            end
        endcase
    end

    // numerator of the mapping, with half a divisor added for rounding
    assign curAdj = {sampleCurrent[`CIS_CUR_W-1], sampleCurrent}
                    + ((accRange == CIS_RNG_BIPOLAR) ? `CIS_I_BIP_SHIFT : 19'sh00000); // R16
    assign subDen = 32'(subC) * 32'(denC);
    assign numS   = $signed({{21{curAdj[18]}}, curAdj}) * $signed({23'h000000, mulC})
                    - $signed({8'h00, subDen})
                    + $signed({25'h0000000, denC[15:1]}); // R18

    // ****************************************
    // divider hookup
    // ****************************************
    assign div.start = accept && !chanOff && !lowHit && !highHit && !overHit && !numS[39];
    assign div.numer = numS[31:0];
    assign div.denom = denC;

    cis_divider #(
        .NUM_W (`CIS_NUM_W),
        .DEN_W (`CIS_DEN_W)
    ) u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .div   (div.calc)
    );

    assign divFinish = state_q == CIS_DIV && div.done;
    // floor of the rounded numerator, held to the 16 bit code space
    assign divCode   = (div.quot[31:16] != 16'h0000) ? `CIS_CODE_MAX : div.quot[15:0]; // R18

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= CIS_IDLE;
            pendChan_q <= '0;
        end
        else if (ce)
        begin
            case (state_q)
                CIS_IDLE:
                begin
                    if (div.start)
                    begin
                        state_q    <= CIS_DIV;
                        pendChan_q <= sampleChan;
                    end
                end
                CIS_DIV:
                begin
                    if (div.done)
                    begin
                        state_q <= CIS_IDLE;
                    end
                end
                default:
                begin
                    state_q <= CIS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // code output
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            codeValid_q <= 1'b0;
            codeChan_q  <= '0;
            codeValue_q <= '0;
        end
        else if (ce)
        begin
            codeValid_q <= 1'b0;
            if (accept && !chanOff && !div.start)
            begin
                codeValid_q <= 1'b1;
                codeChan_q  <= sampleChan;
                codeValue_q <= clampCode; // R3 R4 R6 R7 R10 R11 R14 R15 R17
            end
            else if (divFinish)
            begin
                codeValid_q <= 1'b1;
                codeChan_q  <= pendChan_q;
                codeValue_q <= divCode; // R2 R5 R8 R9 R12 R13 R16
            end
        end
    end

    // ****************************************
    // overflow alarms
    // ****************************************
    // updated on the edge that issues the code; a set beats a disable
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_q <= '0;
        end
        else if (ce)
        begin
            if (ce && cfgValid && cfgRange == CIS_RNG_OFF)
            begin
                alarm_q[cfgChan] <= 1'b0; // R19
            end
            if (divFinish)
            begin
                alarm_q[pendChan_q] <= 1'b0; // R19
            end
            if (accept && !div.start)
            begin
                alarm_q[sampleChan] <= overHit && !chanOff; // R10 R14 R19
            end
        end
    end

    assign codeValid     = codeValid_q;
    assign codeChan      = codeChan_q;
    assign codeValue     = codeValue_q;
    assign overflowAlarm = alarm_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_off_no_code: assert property (accept && chanOff |=> !codeValid) // R1
        else $error("disabled channel produced a code");
    a_full4_low: assert property (accept && accRange == CIS_RNG_4_20_FULL && sampleCurrent < `CIS_I_4MA
        |=> codeValid && codeValue == `CIS_CODE_MIN) // R3
        else $error("4-20 full low clamp wrong");
    a_full_high: assert property (accept && highHit |=> codeValid && codeValue == `CIS_CODE_MAX) // R4
        else $error("high clamp not at max code");
    a_full0_high: assert property (accept && accRange == CIS_RNG_0_20_FULL && sampleCurrent > `CIS_I_20MA
        |=> codeValue == `CIS_CODE_MAX && !overflowAlarm[$past(sampleChan)]) // R6
        else $error("0-20 full high clamp wrong");
    a_full0_low: assert property (accept && accRange == CIS_RNG_0_20_FULL && sampleCurrent < `CIS_I_ZERO
        |=> codeValid && codeValue == `CIS_CODE_MIN) // R7
        else $error("0-20 full low clamp wrong");
    a_s27_4_over: assert property (accept && accRange == CIS_RNG_4_20_S27 && sampleCurrent > `CIS_I_20MA24
        |=> codeValue == `CIS_CODE_OVR_4 && overflowAlarm[$past(sampleChan)]) // R10
        else $error("4-20 scaled overflow wrong");
    a_s27_0_over: assert property (accept && accRange == CIS_RNG_0_20_S27 && sampleCurrent > `CIS_I_20MA24
        |=> codeValue == `CIS_CODE_OVR_0 && overflowAlarm[$past(sampleChan)]) // R14
        else $error("0-20 scaled overflow wrong");
    a_s27_low: assert property (accept && lowHit && (accRange == CIS_RNG_4_20_S27 || accRange == CIS_RNG_0_20_S27)
        |=> codeValid && codeValue == `CIS_CODE_MIN && !overflowAlarm[$past(sampleChan)]) // R11 R15
        else $error("scaled low clamp wrong");
    a_bip_low: assert property (accept && accRange == CIS_RNG_BIPOLAR && sampleCurrent < `CIS_I_NEG20MA
        |=> codeValid && codeValue == `CIS_CODE_MIN) // R17
        else $error("bipolar low clamp wrong");
    a_full4_top: assert property (accept && accRange == CIS_RNG_4_20_FULL && sampleCurrent == `CIS_I_20MA
        |-> ##[1:40] codeValid && codeValue == 16'hffff) // R2
        else $error("4-20 full top point wrong");
    a_full0_mid: assert property (accept && accRange == CIS_RNG_0_20_FULL && sampleCurrent == 18'sh02710
        |-> ##[1:40] codeValid && codeValue == 16'h8000) // R5
        else $error("0-20 full mid point wrong");
    a_round_1ma: assert property (accept && accRange == CIS_RNG_0_20_FULL && sampleCurrent == 18'sh003e8
        |-> ##[1:40] codeValid && codeValue == 16'h0ccd) // R18
        else $error("rounding at 1 mA wrong");
    a_s27_4_top: assert property (accept && accRange == CIS_RNG_4_20_S27 && sampleCurrent == `CIS_I_20MA
        |-> ##[1:40] codeValid && codeValue == 16'h6c00) // R8
        else $error("4-20 scaled top point wrong");
    a_s27_0_mid: assert property (accept && accRange == CIS_RNG_0_20_S27 && sampleCurrent == 18'sh02710
        |-> ##[1:40] codeValid && codeValue == 16'h3600) // R12
        else $error("0-20 scaled mid point wrong");
    a_bip_zero: assert property (accept && accRange == CIS_RNG_BIPOLAR && sampleCurrent == `CIS_I_ZERO
        |-> ##[1:40] codeValid && codeValue == 16'h8000) // R16
        else $error("bipolar zero point wrong");
    a_band_no_alarm: assert property (div.start && sampleCurrent > `CIS_I_20MA
        |-> ##[1:40] codeValid && !overflowAlarm[codeChan]) // R9 R13 R19
        else $error("overshoot band raised alarm");

    c_clamp_over: cover property (accept && overHit ##1 codeValid);
    c_div_path: cover property (div.start ##[1:40] codeValid);
    c_alarm_clear: cover property (overflowAlarm != '0 ##[1:80] overflowAlarm == '0);

endmodule : cis_scaler

/* cis_coupler_model.sv */
// reader model: the fieldbus side that copies each code pulse into its image.
// assumes codes arrive as one-cycle pulses on the scaler clock, never stalled.
`timescale 1ns/1ps
`include "cis_consts.svh"

module cis_coupler_model
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 codeValid,
    input  wire logic [`CIS_CH_W-1:0] codeChan,
    input  wire logic [15:0]          codeValue,
    output logic [15:0]               codeCount,
    output logic [15:0]               lastValue
);
    // take each code in its pulse cycle, the only cycle it is news
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            codeCount <= 16'h0000;
            lastValue <= 16'h0000;
        end
        else if (codeValid)
        begin
            codeCount <= codeCount + 16'h0001;
            lastValue <= codeValue;
        end
    end
endmodule : cis_coupler_model

/* current_input_code_scaler_tb.sv */
// testbench of the current input code scaler with a reference model.
// assumes cis_scaler as top design and the reader model beside it.
`timescale 1ns/1ps
`include "cis_consts.svh"

module current_input_code_scaler_tb;
    import cis_pkg::*;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               ce = 1'b0;
    logic               cfgValid = 1'b0;
    logic [2:0]         cfgChan = 3'h0;
    logic [2:0]         cfgRange = 3'h0;
    logic               sampleValid = 1'b0;
    logic [2:0]         sampleChan = 3'h0;
    logic signed [17:0] sampleCurrent = 18'sh00000;
    logic               sampleReady;
    logic               codeValid;
    logic [2:0]         codeChan;
    logic [15:0]        codeValue;
    logic [7:0]         overflowAlarm;
    logic [15:0]        codeCount;
    logic [15:0]        lastValue;
    int                 rngM [8];
    logic [7:0]         alarmM = 8'h00;
    int                 codesM = 0;
    int                 err_total = 0;
    int                 compares = 0;
    int                 cycles = 0;
    logic [31:0]        seed = 32'h4c01;
    int                 pts [15] = '{-25000, -20000, -1, 0, 1000, 3999, 4000, 10000,
                                     19000, 20000, 20001, 20190, 20240, 20241, 30000};

    // ****************************************
    // clock, instances, timeout
    // ****************************************
    always #20 clk = ~clk;

    cis_scaler i_cis_scaler (.clk(clk), .rst_n(rst_n), .ce(ce), .cfgValid(cfgValid), .cfgChan(cfgChan),
        .cfgRange(cfgRange), .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleChan(sampleChan),
        .sampleCurrent(sampleCurrent), .codeValid(codeValid), .codeChan(codeChan), .codeValue(codeValue),
        .overflowAlarm(overflowAlarm));
    cis_coupler_model i_cis_coupler_model (.clk(clk), .rst_n(rst_n), .codeValid(codeValid),
        .codeChan(codeChan), .codeValue(codeValue), .codeCount(codeCount), .lastValue(lastValue));

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // ****************************************
    // reference model and tasks
    // ****************************************
    function automatic int expCode(input int r, input int i, output bit ovr);
        longint li;
        li = i;
        ovr = (r == 3 || r == 4) && i > 20240;
        if (r == 1) return (i < 4000) ? 0 : (i > 20000) ? 65535 : int'((65535 * li - 262136000) / 16000);
        if (r == 2) return (i < 0) ? 0 : (i > 20000) ? 65535 : int'((65535 * li + 10000) / 20000);
        if (r == 3) return (i < 4000) ? 0 : ovr ? 28085 : int'((27648 * li - 110584000) / 16000);
        if (r == 4) return (i < 0) ? 0 : ovr ? 27986 : int'((27648 * li + 10000) / 20000);
        return (i < -20000) ? 0 : (i > 20000) ? 65535 : int'((65535 * (li + 20000) + 20000) / 40000);
    endfunction : expCode

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk

    task automatic setRange(input int ch, input int r);
        @(posedge clk);
        cfgValid <= 1'b1;
        cfgChan <= ch[2:0];
        cfgRange <= r[2:0];
        @(posedge clk);
        cfgValid <= 1'b0;
        // a write offered while ce is low is never taken
        if (ce && r <= 5) rngM[ch] = r;
        if (ce && r == 0) alarmM[ch] = 1'b0;
    endtask : setRange

    // offer one sample, wait for its code and compare with the model
    task automatic sample(input int ch, input int cur);
        int  e;
        int  n;
        bit  ovr;
        bit  lin;
        @(posedge clk);
        sampleValid <= 1'b1;
        sampleChan <= ch[2:0];
        sampleCurrent <= cur[17:0];
        @(posedge clk);
        sampleValid <= 1'b0;
        if (rngM[ch] == 0)
        begin
            alarmM[ch] = 1'b0;
            repeat (2) @(posedge clk);
            #1 chk("alarm off", alarmM, overflowAlarm);
            return;
        end
        e = expCode(rngM[ch], cur, ovr);
        alarmM[ch] = ovr;
        codesM++;
        n = 0;
        // linear band goes through the divider, everything else is clamped at once
        lin = (cur >= ((rngM[ch] == 1 || rngM[ch] == 3) ? 4000 : (rngM[ch] == 5) ? -20000 : 0))
              && (cur <= ((rngM[ch] == 3 || rngM[ch] == 4) ? 20240 : 20000));
        #1 chk("ready", !lin, sampleReady);
        while (codeValid !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("latency", lin ? 33 : 0, n);
        chk("code", e, codeValue);
        chk("chan", ch, codeChan);
        chk("alarm", alarmM, overflowAlarm);
        @(posedge clk);
        #1 chk("reader", e, lastValue);
        chk("pulse", 0, codeValid);
    endtask : sample

    task automatic report_and_stop();
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        for (int c = 0; c < 8; c++) rngM[c] = 2;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        ce <= 1'b1;
        #1 chk("reset code", 0, {codeValid, codeValue, overflowAlarm});
        chk("reset ready", 1, sampleReady);
        sample(0, 10000);
        $display("test reset and default range done");
        for (int r = 1; r <= 5; r++)
        begin
            setRange(r, r);
            foreach (pts[k]) sample(r, pts[k]);
        end
        $display("test range table done");
        setRange(3, 0);
        #1 chk("alarm disable", alarmM, overflowAlarm);
        sample(3, 5000);
        setRange(4, 6);
        sample(4, 30000);
        // a disable write while ce is low must leave range and alarm alone
        @(posedge clk) ce <= 1'b0;
        setRange(4, 0);
        @(posedge clk) ce <= 1'b1;
        #1 chk("frozen alarm", alarmM, overflowAlarm);
        sample(4, 10000);
        $display("test disable and refused range done");
        repeat (40)
        begin
            seed = lfsr(seed);
            setRange(int'(seed[2:0]), int'(seed[5:3]));
            seed = lfsr(seed);
            sample(int'(seed[2:0]), int'(seed[18:3]) % 50000 - 25000);
        end
        $display("test random samples done");
        chk("code count", codesM, codeCount);
        report_and_stop();
    end
endmodule : current_input_code_scaler_tb
